/* File: rtl/dif_pkg.sv */
// Constants, register map and carrier types of the drive input function logic
//
// Functional notes
// - Seven bit selects choose eight preset speeds.
// - Lowest numbered active select wins.
// - Jog frequency from setting, clamped 10 Hz.
// - Jog applies frequency directly, no ramp.
// - Jog mode: accept while running, stop method.
// - Run direction before jog keeps output off.
// - No jog below start frequency or zero.
// - Brake input forces braking regardless of enable.
// - Brake delay 0.0-5.0 s, coasting meanwhile.
// - Brake force setting 0 to 100 percent.
// - Terminal run: brake release ramps back.
// - Motor set changes only while stopped.
// - Second and third together: second wins.
// - Two-stage input selects second ramp times.
// - Two-stage honoured only when method is 00.
// - Free-run input coasts, release resumes running.
// - Restart from 0 Hz or motor speed.
// - Restart wait before resume, zero skips.
// - Per-terminal polarity makes function active low, except reset and start protection.
// - Trip input edge latches trip code 12.
// - Alarm at once; start protection needs new run.
// - Both run directions active means stop.
// - Reset held 12 ms, release clears trip.
package dif_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;         // 100 MHz control clock
  localparam int TICK_TIME_MS  = 100;        // Setting unit of delays, 0.1 s
  localparam int TICK_CYC      = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RS_HOLD_MS    = 12;         // Least reset input hold time
  localparam int RS_HOLD_CYC   = RS_HOLD_MS * 1000000 / CLK_PERIOD_NS;

  // Frequencies in 0.01 Hz units
  localparam logic [15:0] JOG_MAX_FREQ  = 16'h03e8; // 10.00 Hz
  localparam logic [7:0]  BRK_DLY_MAX   = 8'h32;    // 5.0 s in 0.1 s units
  localparam logic [7:0]  BRK_FORCE_MAX = 8'h64;    // 100 percent
  localparam logic [7:0]  ERR_EXT_TRIP  = 8'h0c;    // Error code 12
  localparam logic [7:0]  MODE_BITLEVEL = 8'h01;    // Bit-level speed mode
  localparam logic [7:0]  TWO_STAGE_PIN = 8'h00;    // Terminal switched ramps
  localparam logic [7:0]  JOG_ACCEPT    = 8'h03;    // Modes 03..05 accept

  // Register offsets (word index on the plain port)
  localparam logic [5:0] REG_PRESET0    = 6'h00; // 0x00..0x07 preset speeds
  localparam logic [5:0] REG_JOG_FREQ   = 6'h08;
  localparam logic [5:0] REG_JOG_MODE   = 6'h09;
  localparam logic [5:0] REG_START_FREQ = 6'h0a;
  localparam logic [5:0] REG_DC_EN      = 6'h0b;
  localparam logic [5:0] REG_DC_DELAY   = 6'h0c;
  localparam logic [5:0] REG_DC_FORCE   = 6'h0d;
  localparam logic [5:0] REG_ACCEL1     = 6'h0e;
  localparam logic [5:0] REG_DECEL1     = 6'h0f;
  localparam logic [5:0] REG_ACCEL2     = 6'h10;
  localparam logic [5:0] REG_DECEL2     = 6'h11;
  localparam logic [5:0] REG_TWO_METHOD = 6'h12;
  localparam logic [5:0] REG_FR_RESTART = 6'h13;
  localparam logic [5:0] REG_RS_WAIT    = 6'h14;
  localparam logic [5:0] REG_POLARITY   = 6'h15;
  localparam logic [5:0] REG_CONTROL    = 6'h16; // Bit 0: run from keypad
  localparam logic [5:0] REG_SPEED_MODE = 6'h17;
  localparam logic [5:0] REG_STATE      = 6'h18; // Read only
  localparam logic [5:0] REG_ERROR      = 6'h19; // Read only
  localparam logic [5:0] REG_FREQ       = 6'h1a; // Read only

  // Reset values
  localparam logic [15:0] RST_JOG_FREQ   = 16'h0258; // 6.00 Hz
  localparam logic [15:0] RST_START_FREQ = 16'h0032; // 0.50 Hz
  localparam logic [15:0] RST_RAMP_TIME  = 16'h03e8; // 10.00 s
  localparam logic [7:0]  RST_SPEED_MODE = 8'h01;

  localparam int TERM_W = 18;

  // Input terminal functions, one bit each
  typedef struct packed {
    logic       start_protection;
    logic       reset_input;
    logic       external_trip_input;
    logic       free_run_input;
    logic       two_stage_ramp_input;
    logic       third_motor_select;
    logic       second_motor_select;
    logic       external_brake_input;
    logic       jog_input;
    logic       reverse_run_input;
    logic       forward_run_input;
    logic [6:0] bit_speed_sel;  // Bit 0 is select 1
  } dif_term_s;

  // Commands toward frequency generation
  typedef struct packed {
    logic        out_en;      // Output stage driving
    logic        reverse;     // Direction
    logic        jog_direct;  // Bypass the ramp
    logic        dc_brake;    // DC injection active
    logic [7:0]  brake_force; // Percent
    logic [15:0] freq_target; // 0.01 Hz
    logic        load;        // One-cycle: preload ramp with load_freq
    logic [15:0] load_freq;
    logic [15:0] accel_time;
    logic [15:0] decel_time;
    logic [1:0]  motor_set;   // 0 first, 1 second, 2 third
    logic        alarm;
    logic [7:0]  err_code;
  } dif_drive_s;

  // Drive sequence states
  typedef enum logic [8:0] {
    ST_STOP     = 9'h001,
    ST_RUN      = 9'h002,
    ST_JOG      = 9'h004,
    ST_DECEL    = 9'h008,
    ST_BRK_WAIT = 9'h010,
    ST_BRAKE    = 9'h020,
    ST_COAST    = 9'h040,
    ST_RWAIT    = 9'h080,
    ST_TRIP     = 9'h100
  } dif_state_e;

endpackage

/* File: rtl/dif_input_logic.sv */
// Drive input terminal function logic with settings on a plain register port
`timescale 1ns/1ps
`default_nettype none
module dif_input_logic import dif_pkg::*; #(
  parameter int TICK_CYCLES    = TICK_CYC,    // 0.1 s time base
  parameter int RS_HOLD_CYCLES = RS_HOLD_CYC  // Least reset input hold
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Input terminals, raw from the pins
  input  wire dif_term_s   term_pins,
  // Same-clock inputs from the rest of the drive
  input  wire logic        keypad_run,
  input  wire logic [15:0] motor_speed,
  input  wire logic        ramp_at_zero,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Commands toward frequency generation
  output dif_drive_s       drive
);

  // Whole module state
  typedef struct packed {
    logic [TERM_W-1:0] sync1;      // Synchroniser stage 1
    logic [TERM_W-1:0] sync2;      // Stage 2
    logic [TERM_W-1:0] sync3;      // Stage 3
    logic [TERM_W-1:0] filt;       // Accepted pin levels
    logic [TERM_W-1:0] act_q;      // Active levels last cycle
    logic [7:0][15:0]  preset;     // Preset speed table
    logic [15:0]       jog_freq;
    logic [7:0]        jog_mode;
    logic [15:0]       start_freq;
    logic              dc_en;
    logic [7:0]        dc_delay;
    logic [7:0]        dc_force;
    logic [15:0]       accel1;
    logic [15:0]       decel1;
    logic [15:0]       accel2;
    logic [15:0]       decel2;
    logic [7:0]        two_method;
    logic              fr_restart;  // 1: resume at motor speed
    logic [7:0]        rs_wait;
    logic [TERM_W-1:0] polarity;
    logic              run_keypad;
    logic [7:0]        speed_mode;
    dif_state_e        st;
    logic [31:0]       tick_cnt;
    logic              tick;
    logic [7:0]        dly_cnt;     // Ticks spent waiting
    logic [31:0]       rs_cnt;      // Cycles reset input held
    logic              jog_brk;     // Braking ends a jog
    logic              blocked;     // Run needs a fresh edge
    logic              run_q;
    logic              rev;
    logic [1:0]        mset;
    logic [15:0]       rdata;
    dif_drive_s        out;
  } dif_regs_s;

  dif_regs_s s_r;   // Registered state
  dif_regs_s s_nxt; // Next state

  dif_term_s   a;        // Active functions after polarity
  logic        run_req;  // Run command from chosen source
  logic        run_rise;
  logic        jog_rise;
  logic        jog_ok;
  logic        trip_edge;
  logic        rs_release;
  logic [2:0]  sel_idx;
  logic [15:0] jog_f;
  logic        two_on;

  // Next state of everything
  always_comb begin
    s_nxt = s_r;

    // Three-stage pin synchroniser, accept when stages 2 and 3 agree
    s_nxt.sync1 = term_pins;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    for (int i = 0; i < TERM_W; i++) begin
      if (s_r.sync2[i] == s_r.sync3[i]) begin
        s_nxt.filt[i] = s_r.sync3[i];
      end
    end

    // Polarity turns a terminal normally closed
    a = dif_term_s'(s_r.filt ^ s_r.polarity);
    s_nxt.act_q = a;

    // Opposite run directions together cancel to stop
    run_req = s_r.run_keypad ? keypad_run
            : (a.forward_run_input ^ a.reverse_run_input);
    s_nxt.run_q = run_req;
    run_rise  = run_req & ~s_r.run_q;
    jog_rise  = a.jog_input & ~s_r.act_q[9];
    trip_edge = a.external_trip_input & ~s_r.act_q[15];

    // Bit-level select: scan down so the lowest active input wins
    sel_idx = 3'h0;
    if (s_r.speed_mode == MODE_BITLEVEL) begin
      for (int i = 6; i >= 0; i--) begin
        if (a.bit_speed_sel[i]) begin
          sel_idx = 3'(i + 1);
        end
      end
    end

    // Jog frequency clamp and validity
    jog_f  = (s_r.jog_freq > JOG_MAX_FREQ) ? JOG_MAX_FREQ
           : s_r.jog_freq;
    jog_ok = (s_r.jog_freq != 16'h0000)
           && (s_r.jog_freq >= s_r.start_freq);

    // 0.1 s time base
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = 32'h0000_0000;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;
    end
    if (s_r.tick) begin
      s_nxt.dly_cnt = s_r.dly_cnt + ((s_r.dly_cnt == 8'hff) ? 8'h00 : 8'h01);
    end

    // Reset input: count hold time; short pulses are ignored
    rs_release = 1'b0;
    if (a.reset_input) begin
      if (s_r.rs_cnt != 32'hffff_ffff) begin
        s_nxt.rs_cnt = s_r.rs_cnt + 32'h0000_0001;
      end
    end else begin
      s_nxt.rs_cnt = 32'h0000_0000;
      rs_release = s_r.act_q[16] && (s_r.rs_cnt >= 32'(RS_HOLD_CYCLES));
    end

    // Run going low lifts the block, so the next run edge starts
    if (!run_req) begin
      s_nxt.blocked = 1'b0;
    end

    // Direction follows the terminal that commands run
    if (!s_r.run_keypad && run_req) begin
      s_nxt.rev = a.reverse_run_input;
    end

    // Sequence; trip and reset come before anything else
    if (trip_edge) begin
      s_nxt.st = ST_TRIP;
    end else if (rs_release) begin
      // Powerup-style reset clears the trip
      s_nxt.st      = ST_STOP;
      s_nxt.blocked = a.start_protection & run_req;
    end else if (a.reset_input) begin
      s_nxt.st = s_r.st; // Frozen, output held off below
    end else begin
      case (s_r.st)
        ST_STOP: begin
          if (a.external_brake_input) begin
            s_nxt.st      = ST_BRK_WAIT;
            s_nxt.dly_cnt = 8'h00;
            s_nxt.jog_brk = 1'b0;
          end else if (a.jog_input) begin
            // Run must follow jog; an old run keeps output off
            if (run_rise && jog_ok) begin
              s_nxt.st = ST_JOG;
            end
          end else if (run_req && !s_r.blocked) begin
            s_nxt.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (a.free_run_input) begin
            s_nxt.st = ST_COAST;
          end else if (a.external_brake_input) begin
            s_nxt.st      = ST_BRK_WAIT;
            s_nxt.dly_cnt = 8'h00;
            s_nxt.jog_brk = 1'b0;
          end else if (!run_req) begin
            s_nxt.st = ST_DECEL;
          end else if (jog_rise && jog_ok
                       && s_r.jog_mode >= JOG_ACCEPT) begin
            s_nxt.st = ST_JOG;
          end
        end
        ST_JOG: begin
          if (a.free_run_input) begin
            s_nxt.st = ST_COAST;
          end else if (!a.jog_input || !run_req) begin
            // Stop method from jog mode: 00/03, 01/04, 02/05
            case (s_r.jog_mode)
              8'h00, 8'h03: s_nxt.st = ST_STOP;
              8'h01, 8'h04: s_nxt.st = ST_DECEL;
              default: begin
                s_nxt.st      = ST_BRK_WAIT;
                s_nxt.dly_cnt = 8'h00;
                s_nxt.jog_brk = 1'b1;
              end
            endcase
            s_nxt.blocked = run_req;
          end
        end
        ST_DECEL: begin
          if (a.free_run_input) begin
            s_nxt.st = ST_COAST;
          end else if (a.external_brake_input) begin
            s_nxt.st      = ST_BRK_WAIT;
            s_nxt.dly_cnt = 8'h00;
            s_nxt.jog_brk = 1'b0;
          end else if (run_req && !s_r.blocked) begin
            s_nxt.st = ST_RUN;
          end else if (ramp_at_zero) begin
            s_nxt.st = ST_STOP;
          end
        end
        ST_BRK_WAIT: begin
          // Coast until the delay expires, zero skips it
          if (s_r.dly_cnt >= s_r.dc_delay) begin
            s_nxt.st = ST_BRAKE;
          end
        end
        ST_BRAKE: begin
          if (s_r.jog_brk) begin
            if (!run_req) begin
              s_nxt.st = ST_STOP;
            end
          end else if (!a.external_brake_input) begin
            if (!s_r.run_keypad && run_req) begin
              s_nxt.st = ST_RUN;
            end else begin
              s_nxt.st      = ST_STOP;
              s_nxt.blocked = run_req;
            end
          end
        end
        ST_COAST: begin
          if (!a.free_run_input) begin
            s_nxt.st      = run_req ? ST_RWAIT : ST_STOP;
            s_nxt.dly_cnt = 8'h00;
          end
        end
        ST_RWAIT: begin
          if (a.free_run_input || !run_req) begin
            s_nxt.st = a.free_run_input ? ST_COAST : ST_STOP;
          end else if (s_r.dly_cnt >= s_r.rs_wait) begin
            s_nxt.st = ST_RUN;
          end
        end
        ST_TRIP: s_nxt.st = ST_TRIP; // Held until reset
        default: s_nxt.st = ST_STOP;
      endcase
    end

    // Motor set follows its inputs only while stopped
    if (s_r.st == ST_STOP) begin
      if (a.second_motor_select) begin
        s_nxt.mset = 2'h1;
      end else if (a.third_motor_select) begin
        s_nxt.mset = 2'h2;
      end else begin
        s_nxt.mset = 2'h0;
      end
    end

    // Ramp times; the pin counts only in terminal method
    two_on = a.two_stage_ramp_input
           && (s_r.two_method == TWO_STAGE_PIN);
    s_nxt.out.accel_time = two_on ? s_r.accel2 : s_r.accel1;
    s_nxt.out.decel_time = two_on ? s_r.decel2 : s_r.decel1;

    // Output commands from the sequence state
    s_nxt.out.out_en      = 1'b0;
    s_nxt.out.jog_direct  = 1'b0;
    s_nxt.out.dc_brake    = 1'b0;
    s_nxt.out.freq_target = 16'h0000;
    s_nxt.out.load        = 1'b0;
    s_nxt.out.load_freq   = 16'h0000;
    s_nxt.out.reverse     = s_r.rev;
    s_nxt.out.brake_force = s_r.dc_force;
    s_nxt.out.motor_set   = s_r.mset;
    case (s_r.st)
      ST_RUN: begin
        s_nxt.out.out_en      = 1'b1;
        s_nxt.out.freq_target = s_r.preset[sel_idx];
      end
      ST_JOG: begin
        s_nxt.out.out_en      = 1'b1;
        s_nxt.out.jog_direct  = 1'b1;
        s_nxt.out.freq_target = jog_f;
      end
      ST_DECEL: s_nxt.out.out_en = 1'b1;
      ST_BRAKE: s_nxt.out.dc_brake = 1'b1;
      default: s_nxt.out.out_en = 1'b0; // Coasting or stopped
    endcase
    // Resume after free-run preloads the ramp
    if (s_r.st == ST_RWAIT && s_nxt.st == ST_RUN) begin
      s_nxt.out.load      = 1'b1;
      s_nxt.out.load_freq = s_r.fr_restart ? motor_speed : 16'h0000;
    end
    // Reset, free-run and trip hold the output off, even mid-transition
    if (a.reset_input || a.free_run_input || s_r.st == ST_TRIP) begin
      s_nxt.out.out_en   = 1'b0;
      s_nxt.out.dc_brake = 1'b0;
    end
    // Alarm at once on the edge, cleared by the reset release
    if (trip_edge) begin
      s_nxt.out.alarm    = 1'b1;
      s_nxt.out.err_code = ERR_EXT_TRIP;
      s_nxt.out.out_en   = 1'b0;
      s_nxt.out.dc_brake = 1'b0;
    end else if (rs_release) begin
      s_nxt.out.alarm    = 1'b0;
      s_nxt.out.err_code = 8'h00;
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr <= REG_PRESET0 + 6'h07) begin
        s_nxt.preset[reg_addr[2:0]] = reg_wdata;
      end
      case (reg_addr)
        REG_JOG_FREQ:   s_nxt.jog_freq   = reg_wdata;
        REG_JOG_MODE:   s_nxt.jog_mode   = (reg_wdata[7:0] > 8'h05)
                                           ? 8'h05 : reg_wdata[7:0];
        REG_START_FREQ: s_nxt.start_freq = reg_wdata;
        REG_DC_EN:      s_nxt.dc_en      = reg_wdata[0];
        REG_DC_DELAY:   s_nxt.dc_delay   = (reg_wdata[7:0] > BRK_DLY_MAX)
                                           ? BRK_DLY_MAX
                                           : reg_wdata[7:0];
        REG_DC_FORCE:   s_nxt.dc_force   = (reg_wdata[7:0] > BRK_FORCE_MAX)
                                           ? BRK_FORCE_MAX
                                           : reg_wdata[7:0];
        REG_ACCEL1:     s_nxt.accel1     = reg_wdata;
        REG_DECEL1:     s_nxt.decel1     = reg_wdata;
        REG_ACCEL2:     s_nxt.accel2     = reg_wdata;
        REG_DECEL2:     s_nxt.decel2     = reg_wdata;
        REG_TWO_METHOD: s_nxt.two_method = reg_wdata[7:0];
        REG_FR_RESTART: s_nxt.fr_restart = reg_wdata[0];
        REG_RS_WAIT:    s_nxt.rs_wait    = reg_wdata[7:0];
        REG_POLARITY:   s_nxt.polarity   = {2'h0, reg_wdata};
        REG_CONTROL:    s_nxt.run_keypad = reg_wdata[0];
        REG_SPEED_MODE: s_nxt.speed_mode = reg_wdata[7:0];
        default: ; // Preset range handled above; read-only and unmapped ignored
      endcase
    end

    // Register reads, data in the next cycle only
    s_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr <= REG_PRESET0 + 6'h07) begin
        s_nxt.rdata = s_r.preset[reg_addr[2:0]];
      end
      case (reg_addr)
        REG_JOG_FREQ:   s_nxt.rdata = s_r.jog_freq;
        REG_JOG_MODE:   s_nxt.rdata = {8'h00, s_r.jog_mode};
        REG_START_FREQ: s_nxt.rdata = s_r.start_freq;
        REG_DC_EN:      s_nxt.rdata = {15'h0000, s_r.dc_en};
        REG_DC_DELAY:   s_nxt.rdata = {8'h00, s_r.dc_delay};
        REG_DC_FORCE:   s_nxt.rdata = {8'h00, s_r.dc_force};
        REG_ACCEL1:     s_nxt.rdata = s_r.accel1;
        REG_DECEL1:     s_nxt.rdata = s_r.decel1;
        REG_ACCEL2:     s_nxt.rdata = s_r.accel2;
        REG_DECEL2:     s_nxt.rdata = s_r.decel2;
        REG_TWO_METHOD: s_nxt.rdata = {8'h00, s_r.two_method};
        REG_FR_RESTART: s_nxt.rdata = {15'h0000, s_r.fr_restart};
        REG_RS_WAIT:    s_nxt.rdata = {8'h00, s_r.rs_wait};
        REG_POLARITY:   s_nxt.rdata = s_r.polarity[15:0];
        REG_CONTROL:    s_nxt.rdata = {15'h0000, s_r.run_keypad};
        REG_SPEED_MODE: s_nxt.rdata = {8'h00, s_r.speed_mode};
        REG_STATE:      s_nxt.rdata = {5'h00, s_r.mset, 9'(s_r.st)};
        REG_ERROR:      s_nxt.rdata = {7'h00, s_r.out.alarm,
                                       s_r.out.err_code};
        REG_FREQ:       s_nxt.rdata = s_r.out.freq_target;
        default: ; // Unmapped reads return zero
      endcase
    end
  end

  // State register, synchronous reset to constants
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r            <= '0;
      s_r.jog_freq   <= RST_JOG_FREQ;
      s_r.start_freq <= RST_START_FREQ;
      s_r.accel1     <= RST_RAMP_TIME;
      s_r.decel1     <= RST_RAMP_TIME;
      s_r.accel2     <= RST_RAMP_TIME;
      s_r.decel2     <= RST_RAMP_TIME;
      s_r.speed_mode <= RST_SPEED_MODE;
      s_r.st         <= ST_STOP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = s_r.rdata;
  assign drive     = s_r.out;

endmodule // dif_input_logic
`default_nettype wire

/* File: testbench/dif_input_logic_checker.sv */
// Port checker bound onto the drive input function logic
`timescale 1ns/1ps
`default_nettype none
module dif_input_logic_checker import dif_pkg::*; (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Watched ports
  input wire dif_term_s   term_pins,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire dif_drive_s  drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Jog frequency held under the clamp
  chk_jog_clamp: assert property (
    drive.jog_direct |-> drive.freq_target <= JOG_MAX_FREQ)
    else $error("jog frequency above clamp");
  // Read data only in the cycle after a read
  chk_rd_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  // Trip code means alarm and output off
  chk_trip_off: assert property (
    drive.err_code == ERR_EXT_TRIP |-> drive.alarm && !drive.out_en)
    else $error("trip without alarm or with output on");
  // Both directions at once stop the drive
  chk_both_run: assert property (
    (term_pins.forward_run_input && term_pins.reverse_run_input
     && !term_pins.external_brake_input)[*8] |=> !drive.out_en)
    else $error("output on with both directions");
  // Force never beyond full scale
  chk_force_max: assert property (
    drive.brake_force <= BRK_FORCE_MAX)
    else $error("brake force above full scale");
  // Trip latched while the reset terminal stays off
  chk_trip_hold: assert property (
    (drive.alarm && !term_pins.reset_input)[*8] |=> drive.alarm)
    else $error("trip dropped without reset");
  // Alarm follows a trip edge within the pin latency
  chk_trip_fast: assert property (
    $rose(term_pins.external_trip_input) && !term_pins.reset_input
    |-> ##[1:8] drive.alarm)
    else $error("alarm late after trip edge");
  // Only three motor sets exist
  chk_mset_range: assert property (
    drive.motor_set != 2'h3)
    else $error("motor set code out of range");
endmodule // dif_input_logic_checker
bind dif_input_logic dif_input_logic_checker u_chk (
  .clk(clk), .reset(reset), .term_pins(term_pins), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .drive(drive));
`default_nettype wire

/* File: testbench/dif_term_model.sv */
// Switch and controller model that drives the input terminals
`timescale 1ns/1ps
`default_nettype none
module dif_term_model import dif_pkg::*; (
  // Clock
  input wire logic      clk,
  // Requested levels and resulting pins
  input wire dif_term_s cmd,
  output var dif_term_s pins
);
  logic [1:0] d1, d2, d3; // Run bits, delayed copies
  // Run follows jog by three cycles so jog is always first
  always_ff @(posedge clk) begin
    {d3, d2, d1} <= {d2, d1, cmd.reverse_run_input, cmd.forward_run_input};
    pins <= cmd;
    if (cmd.jog_input) begin
      {pins.reverse_run_input, pins.forward_run_input} <= d3;
    end
  end
endmodule // dif_term_model
`default_nettype wire

/* File: testbench/dif_input_logic_bench.sv */
// Self-checking bench for the drive input function logic
`timescale 1ns/1ps
`default_nettype none
module dif_input_logic_bench import dif_pkg::*;;
  logic        clk = 0;       // 100 MHz
  logic        reset = 1;     // Synchronous, high
  dif_term_s   cmd = '0;      // Requested switch levels
  dif_term_s   term_pins;     // Pins from the model
  logic [5:0]  reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic        kp = 0;        // Keypad run level
  logic [15:0] reg_rdata;
  dif_drive_s  drive;
  logic [15:0] spd [8];       // Preset speeds as written
  logic [15:0] jf [3] = '{16'h0000, 16'h0010, 16'h1388}; // Jog cases
  logic [6:0]  sel;
  logic [7:0]  bf;
  int          fail_count = 0;
  int          total_checks = 0;
  always #5 clk = ~clk;
  dif_term_model u_sw (.clk(clk), .cmd(cmd), .pins(term_pins));
  // Short time bases keep the run brief
  dif_input_logic #(.TICK_CYCLES(10), .RS_HOLD_CYCLES(20)) u_dut (
    .clk(clk), .reset(reset), .term_pins(term_pins), .keypad_run(kp),
    .motor_speed(16'h0100), .ramp_at_zero(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drive(drive));
  // Word compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Flag compare
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  // Lowest active select picks the speed
  function automatic int sel_idx(input logic [6:0] s);
    for (int b = 0; b < 7; b++) if (s[b]) return b + 1;
    return 0;
  endfunction
  function automatic logic [15:0] jog_exp(input logic [15:0] f);
    return (f > JOG_MAX_FREQ) ? JOG_MAX_FREQ : f;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well past the expected run
  initial begin
    #300us;
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'hdaab84ce));
    wt(16); reset <= 0; wt(2);
    rd(REG_STATE, 16'h0001);
    rd(REG_JOG_FREQ, RST_JOG_FREQ);
    rd(6'h3f, 16'h0000);
    wr(REG_STATE, 16'h00ff);
    rd(REG_STATE, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      spd[i] = 16'($urandom_range(6000));
      wr(REG_PRESET0 + 6'(i), spd[i]);
    end
    rd(REG_PRESET0 + 6'h7, spd[7]);
    cmd.forward_run_input <= 1;
    // Random higher selects ride above the winning one
    for (int i = 0; i < 8; i++) begin
      sel = (i == 0) ? 7'h00 : (((7'($urandom) >> i) << i) | (7'h1 << (i - 1)));
      cmd.bit_speed_sel <= sel;
      wt(12); chk(drive.freq_target, spd[sel_idx(sel)]);
    end
    cmd.reverse_run_input <= 1;
    wt(12); chkb(drive.out_en, 1'b0);
    cmd <= '0; wt(12);
    foreach (jf[k]) begin
      wr(REG_JOG_FREQ, jf[k]);
      cmd.jog_input <= 1; cmd.forward_run_input <= 1; wt(14);
      chkb(drive.out_en, jf[k] >= RST_START_FREQ);
      if (k == 2) chk(drive.freq_target, jog_exp(jf[k]));
      if (k == 2) chkb(drive.jog_direct, 1'b1);
      cmd <= '0; wt(12);
    end
    bf = 8'($urandom_range(100));
    wr(REG_DC_DELAY, 16'h0002); wr(REG_DC_FORCE, {8'h0, bf});
    cmd.forward_run_input <= 1; wt(12);
    cmd.external_brake_input <= 1; wt(8);
    chkb(drive.out_en | drive.dc_brake, 1'b0);
    wt(24); chkb(drive.dc_brake, 1'b1);
    chk({8'h0, drive.brake_force}, {8'h0, bf});
    cmd.external_brake_input <= 0; wt(12);
    chkb(drive.out_en, 1'b1);
    cmd.external_trip_input <= 1; wt(8);
    chk({8'h0, drive.err_code}, {8'h0, ERR_EXT_TRIP});
    chkb(drive.alarm, 1'b1);
    cmd.external_trip_input <= 0; wt(12);
    chkb(drive.alarm & ~drive.out_en, 1'b1);
    cmd.reset_input <= 1; wt(30); cmd.reset_input <= 0; wt(12);
    chkb(drive.alarm, 1'b0);
    chkb(drive.out_en, 1'b1);
    cmd <= '0; wt(12);
    cmd.second_motor_select <= 1; cmd.third_motor_select <= 1; wt(12);
    chk({14'h0, drive.motor_set}, 16'h0001);
    // Second ramp set and direction while running in reverse
    wr(REG_DECEL2, 16'h0123);
    cmd.two_stage_ramp_input <= 1; cmd.reverse_run_input <= 1; wt(12);
    chk(drive.decel_time, 16'h0123);
    chkb(drive.reverse, 1'b1);
    cmd.second_motor_select <= 0; cmd.third_motor_select <= 0;
    wr(REG_TWO_METHOD, 16'h0001); wt(12);
    chk(drive.decel_time, RST_RAMP_TIME);
    chk({14'h0, drive.motor_set}, 16'h0001);
    cmd <= '0; wt(12);
    chk({14'h0, drive.motor_set}, 16'h0000);
    // Keypad run, brake applied and released: output stays off
    wr(REG_CONTROL, 16'h0001); kp <= 1; cmd.external_brake_input <= 1;
    wt(40); cmd.external_brake_input <= 0; wt(12);
    chkb(drive.out_en, 1'b0);
    kp <= 0; wr(REG_CONTROL, 16'h0000);
    // Free-run terminal made active low
    wr(REG_POLARITY, 16'h4000); cmd.forward_run_input <= 1; wt(12);
    chkb(drive.out_en, 1'b0);
    cmd.free_run_input <= 1; wt(12);
    chkb(drive.out_en, 1'b1);
    final_report();
  end
endmodule // dif_input_logic_bench
`default_nettype wire
